// *** include/surf_pkg.sv ***
// shared constants and types for the surface descriptor decoder and its requester
package surf_pkg;

  // ----------------------------------------------------------------
  // descriptor dword layout
  // ----------------------------------------------------------------
  localparam int DESC_W     = 32;
  localparam int TYPE_LSB   = 29;
  localparam int TYPE_W     = 3;
  localparam int ARRAY_BIT  = 28;
  localparam int MBZ_BIT    = 27;
  localparam int FMT_LSB    = 18;
  localparam int FMT_W      = 9;
  localparam int VALIGN_LSB = 16;
  localparam int VALIGN_W   = 2;

  // ----------------------------------------------------------------
  // surface type codes
  // ----------------------------------------------------------------
  typedef logic [TYPE_W-1:0] stype_t;
  localparam stype_t one_dim_type           = 3'h0;
  localparam stype_t two_dim_type           = 3'h1;
  localparam stype_t volume_type            = 3'h2;
  localparam stype_t cubemap_type           = 3'h3;
  localparam stype_t element_buffer_type    = 3'h4;
  localparam stype_t structured_buffer_type = 3'h5;
  localparam stype_t reserved_surface_type  = 3'h6;
  localparam stype_t unbound_surface_type   = 3'h7;

  // ----------------------------------------------------------------
  // vertical alignment, formats, multisample
  // ----------------------------------------------------------------
  typedef logic [VALIGN_W-1:0] valign_t;
  typedef logic [FMT_W-1:0]    fmt_t;
  localparam valign_t vert_align_two_rows      = 2'h0;
  localparam valign_t vert_align_four_rows     = 2'h1;
  localparam valign_t vert_align_first_rsvd    = 2'h2;
  localparam fmt_t    packed_luma_chroma_plain  = 9'h182;
  localparam fmt_t    packed_luma_chroma_swap_a = 9'h183;
  localparam fmt_t    packed_luma_chroma_swap_b = 9'h18f;
  localparam fmt_t    packed_luma_chroma_swap_c = 9'h190;
  localparam logic [2:0] single_sample_count    = 3'h0;

  // ----------------------------------------------------------------
  // message link
  // ----------------------------------------------------------------
  localparam int MSG_ADDR_W = 32;
  localparam int MSG_DATA_W = 32;
  typedef enum logic [2:0] {
    msg_sample, msg_read, msg_write, msg_rt_write, msg_media_read, msg_media_write
  } msg_kind_t;
  typedef enum logic [1:0] {resp_ok, resp_dropped, resp_zero, resp_error} resp_t;

  // ----------------------------------------------------------------
  // requester register port
  // ----------------------------------------------------------------
  localparam int         REG_ADDR_W   = 8;
  localparam logic [7:0] OFS_DESC     = 8'h00;
  localparam logic [7:0] OFS_ADDR     = 8'h04;
  localparam logic [7:0] OFS_WDATA    = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0c;
  localparam logic [7:0] OFS_CFG      = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_RDATA    = 8'h18;
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_GO_BIT   = 8;
  localparam int CFG_DEPTH_LSB = 0;
  localparam int CFG_MS_LSB    = 4;
  localparam int CFG_WIDE_BIT  = 8;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_REFUSE_BIT = 2;
  localparam int ST_RESP_LSB   = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// *** include/surf_msg_if.sv ***
// message link between a requesting thread end and the surface decoder end
`timescale 1ns/10ps
interface surf_msg_if;
  import surf_pkg::*;

  logic                  req_valid;
  logic                  req_ready;
  msg_kind_t             req_kind;
  logic [DESC_W-1:0]     req_desc;
  logic [MSG_ADDR_W-1:0] req_addr;
  logic [MSG_DATA_W-1:0] req_wdata;
  logic                  resp_valid;
  resp_t                 resp_status;
  logic [MSG_DATA_W-1:0] resp_data;

  modport device (
    input  req_valid, req_kind, req_desc, req_addr, req_wdata,
    output req_ready, resp_valid, resp_status, resp_data
  );

  modport requester (
    output req_valid, req_kind, req_desc, req_addr, req_wdata,
    input  req_ready, resp_valid, resp_status, resp_data
  );
endinterface

// *** core/surf_field_decode.sv ***
// combinational split of one descriptor dword into its fields
`timescale 1ns/10ps
module surf_field_decode
  import surf_pkg::*;
#(
  parameter fmt_t COMP_FMT_LO = 9'h1ff,
  parameter fmt_t COMP_FMT_HI = 9'h1ff
) (
  // descriptor in
  input  wire logic [DESC_W-1:0] desc,
  // fields out
  output stype_t                 stype,
  output logic                   is_null,
  output logic                   is_rsvd_type,
  output logic                   array_eff,
  output fmt_t                   fmt,
  output logic                   mbz_err,
  output valign_t                valign,
  output logic                   valign_rsvd,
  output logic                   compressed
);

  if (COMP_FMT_LO > COMP_FMT_HI) begin : g_chk
    $error("compressed format range is inverted");
  end

  always_comb begin
    stype        = desc[TYPE_LSB +: TYPE_W];
    is_null      = (stype == unbound_surface_type);
    is_rsvd_type = (stype == reserved_surface_type);
    // array only means something for these types
    array_eff    = desc[ARRAY_BIT] && ((stype == one_dim_type) || (stype == two_dim_type) ||
                   (stype == cubemap_type));
    fmt          = desc[FMT_LSB +: FMT_W];
    mbz_err      = desc[MBZ_BIT];
    valign       = desc[VALIGN_LSB +: VALIGN_W];
    valign_rsvd  = (valign >= vert_align_first_rsvd);
    compressed   = (fmt >= COMP_FMT_LO) && (fmt <= COMP_FMT_HI);
  end

endmodule

// *** core/surface_state_decode.sv ***
// device end: decodes a surface descriptor per message and performs or suppresses the access
//
// Behaviour
// - type 7h is null, 6h reserved
// - writes to null surface are dropped, except media block writes
// - null surface ignores all other fields (the requester still refuses one with bit 27 set, bit 28 set, or a packed format with alignment 1h)
// - media block messages reject null surfaces
// - render target type matches depth buffer
// - bit 28 marks array for 1D/2D/cube
// - format in bits 26:18, bit 27 zero
// - multisampled surfaces at most 64 bits/element
// - vertical alignment only uncompressed sample/RT; 2h-3h reserved
// - codes 0h-3h: 1D, 2D, volume, cube
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module surface_state_decode
  import surf_pkg::*;
#(
  parameter fmt_t COMP_FMT_LO = 9'h1ff,
  parameter fmt_t COMP_FMT_HI = 9'h1ff
) (
  // clock, reset, enable
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESETN,
  input  wire logic                  CE,
  // message link
  surf_msg_if.device                 LINK,
  // memory side
  output logic                       MEM_RD,
  output logic                       MEM_WR,
  output logic [MSG_ADDR_W-1:0]      MEM_ADDR,
  output logic [MSG_DATA_W-1:0]      MEM_WDATA,
  input  wire logic [MSG_DATA_W-1:0] MEM_RDATA,
  // decode report of the last accepted message
  output stype_t                     LAST_TYPE,
  output logic                       LAST_ARRAY,
  output fmt_t                       LAST_FORMAT,
  output valign_t                    LAST_VALIGN,
  output resp_t                      LAST_RESP
);

  // ----------------------------------------------------------------
  // types and signals
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {st_idle, st_rd_wait, st_rd_take, st_done} state_t;
  typedef enum logic [2:0] {act_error, act_drop, act_zero, act_mem_wr, act_mem_rd} act_t;

  state_t  state_q;
  state_t  state_d;
  act_t    act;
  stype_t  stype;
  fmt_t    fmt;
  valign_t valign;
  logic    is_null;
  logic    is_rsvd_type;
  logic    array_eff;
  logic    mbz_err;
  logic    valign_rsvd;
  logic    compressed;
  logic    is_wr_kind;
  logic    is_media;
  logic    va_applies;
  logic    accept;
  logic    ready_q;
  logic    resp_valid_q;
  resp_t   resp_status_q;
  logic [MSG_DATA_W-1:0] resp_data_q;
  logic    mem_rd_q;
  logic    mem_wr_q;
  logic [MSG_ADDR_W-1:0] mem_addr_q;
  logic [MSG_DATA_W-1:0] mem_wdata_q;
  stype_t  last_type_q;
  logic    last_array_q;
  fmt_t    last_fmt_q;
  valign_t last_valign_q;
  resp_t   last_resp_q;

  // ----------------------------------------------------------------
  // descriptor fields
  // ----------------------------------------------------------------
  surf_field_decode #(
    .COMP_FMT_LO (COMP_FMT_LO),
    .COMP_FMT_HI (COMP_FMT_HI)
  ) u_fields (
    .desc         (LINK.req_desc),
    .stype        (stype),
    .is_null      (is_null),
    .is_rsvd_type (is_rsvd_type),
    .array_eff    (array_eff),
    .fmt          (fmt),
    .mbz_err      (mbz_err),
    .valign       (valign),
    .valign_rsvd  (valign_rsvd),
    .compressed   (compressed)
  );

  // ----------------------------------------------------------------
  // verdict per message
  // ----------------------------------------------------------------
  assign accept = CE && ready_q && LINK.req_valid && (state_q == st_idle);

  always_comb begin
    is_wr_kind = (LINK.req_kind == msg_write) || (LINK.req_kind == msg_rt_write) ||
                 (LINK.req_kind == msg_media_write);
    is_media   = (LINK.req_kind == msg_media_read) || (LINK.req_kind == msg_media_write);
    va_applies = !compressed && ((LINK.req_kind == msg_sample) ||
                 (LINK.req_kind == msg_rt_write));
    act        = is_wr_kind ? act_mem_wr : act_mem_rd;
    if (is_rsvd_type) begin
      act = act_error;
    end else if (is_null) begin
      if (is_media) begin
        act = act_error;
      end else if (is_wr_kind) begin
        act = act_drop;
      end else begin
        act = act_zero;
      end
    end else if (mbz_err || (va_applies && valign_rsvd)) begin
      act = act_error;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (accept) begin
          state_d = (act == act_mem_rd) ? st_rd_wait : st_done;
        end
      end
      st_rd_wait: state_d = st_rd_take;
      st_rd_take: state_d = st_done;
      st_done:    state_d = st_idle;
      default:    state_d = st_idle;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= st_idle;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ready_q       <= 1'b0;
      resp_valid_q  <= 1'b0;
      resp_status_q <= resp_ok;
      resp_data_q   <= '0;
    end else if (CE) begin
      resp_valid_q <= 1'b0;
      if (state_q == st_idle) begin
        ready_q <= !accept;
      end else if (state_q == st_done) begin
        ready_q <= 1'b1;
      end
      if (accept && (act != act_mem_rd)) begin
        resp_valid_q <= 1'b1;
        resp_data_q  <= '0;
        case (act)
          act_error: resp_status_q <= resp_error;
          act_drop:  resp_status_q <= resp_dropped;
          act_zero:  resp_status_q <= resp_zero;
          default:   resp_status_q <= resp_ok;
        endcase
      end else if (state_q == st_rd_take) begin
        resp_valid_q  <= 1'b1;
        resp_status_q <= resp_ok;
        resp_data_q   <= MEM_RDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory strobes, never raised for a null surface
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= '0;
      mem_wdata_q <= '0;
    end else if (CE) begin
      mem_rd_q <= accept && (act == act_mem_rd);
      mem_wr_q <= accept && (act == act_mem_wr);
      if (accept) begin
        mem_addr_q  <= LINK.req_addr;
        mem_wdata_q <= LINK.req_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // decode report; null surfaces show only their type
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      last_type_q   <= one_dim_type;
      last_array_q  <= 1'b0;
      last_fmt_q    <= '0;
      last_valign_q <= vert_align_two_rows;
      last_resp_q   <= resp_ok;
    end else if (CE) begin
      if (accept) begin
        last_type_q   <= stype;
        last_array_q  <= array_eff && !is_null;
        last_fmt_q    <= is_null ? '0 : fmt;
        last_valign_q <= (is_null || !va_applies) ? vert_align_two_rows : valign;
      end
      if (resp_valid_q) begin
        last_resp_q <= resp_status_q;
      end
    end
  end

  assign LINK.req_ready   = ready_q;
  assign LINK.resp_valid  = resp_valid_q;
  assign LINK.resp_status = resp_status_q;
  assign LINK.resp_data   = resp_data_q;
  assign MEM_RD           = mem_rd_q;
  assign MEM_WR           = mem_wr_q;
  assign MEM_ADDR         = mem_addr_q;
  assign MEM_WDATA        = mem_wdata_q;
  assign LAST_TYPE        = last_type_q;
  assign LAST_ARRAY       = last_array_q;
  assign LAST_FORMAT      = last_fmt_q;
  assign LAST_VALIGN      = last_valign_q;
  assign LAST_RESP        = last_resp_q;

endmodule

// *** core/surface_requester.sv ***
// requesting end: software-programmed issue of surface messages with descriptor checks
`timescale 1ns/10ps
module surface_requester
  import surf_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESETN,
  input  wire logic                  CE,
  // software register port
  input  wire logic [REG_ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic [31:0]                REG_RDATA,
  // message link
  surf_msg_if.requester              LINK
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {rq_idle, rq_issue, rq_wait} rq_state_t;

  rq_state_t state_q;
  logic [31:0] desc_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [31:0] reg_rdata_q;
  logic [2:0]  kind_q;
  stype_t      depth_q;
  logic [2:0]  ms_q;
  logic        wide_q;
  logic        done_q;
  logic        refuse_q;
  resp_t       resp_q;
  logic        go;
  logic        bad;
  stype_t      stype;
  fmt_t        fmt;
  logic        fire;
  logic        w1c_done;
  logic        w1c_refuse;

  // ----------------------------------------------------------------
  // descriptor checks before issue
  // ----------------------------------------------------------------
  always_comb begin
    stype = desc_q[TYPE_LSB +: TYPE_W];
    fmt   = desc_q[FMT_LSB +: FMT_W];
    bad   = (kind_q > 3'(msg_media_write));
    bad   = bad || desc_q[MBZ_BIT];
    bad   = bad || (desc_q[ARRAY_BIT] && !((stype == one_dim_type) ||
            (stype == two_dim_type) || (stype == cubemap_type)));
    bad   = bad || ((ms_q != single_sample_count) && wide_q);
    bad   = bad || ((desc_q[VALIGN_LSB +: VALIGN_W] == vert_align_four_rows) &&
            ((fmt == packed_luma_chroma_plain) || (fmt == packed_luma_chroma_swap_a) ||
             (fmt == packed_luma_chroma_swap_b) || (fmt == packed_luma_chroma_swap_c)));
    bad   = bad || ((kind_q == 3'(msg_rt_write)) && (stype != depth_q) &&
            (stype != unbound_surface_type) && (depth_q != unbound_surface_type));
  end

  assign go         = CE && REG_WR && (REG_ADDR == OFS_CTRL) && REG_WDATA[CTRL_GO_BIT];
  assign fire       = go && (state_q == rq_idle) && !bad;
  assign w1c_done   = CE && REG_WR && (REG_ADDR == OFS_STATUS) && REG_WDATA[ST_DONE_BIT];
  assign w1c_refuse = CE && REG_WR && (REG_ADDR == OFS_STATUS) && REG_WDATA[ST_REFUSE_BIT];

  // ----------------------------------------------------------------
  // software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      desc_q  <= RST_WORD;
      addr_q  <= RST_WORD;
      wdata_q <= RST_WORD;
      kind_q  <= 3'h0;
      depth_q <= one_dim_type;
      ms_q    <= single_sample_count;
      wide_q  <= 1'b0;
    end else if (CE && REG_WR && (state_q == rq_idle)) begin
      case (REG_ADDR)
        OFS_DESC:  desc_q  <= REG_WDATA;
        OFS_ADDR:  addr_q  <= REG_WDATA;
        OFS_WDATA: wdata_q <= REG_WDATA;
        OFS_CTRL:  kind_q  <= REG_WDATA[CTRL_KIND_LSB +: 3];
        OFS_CFG: begin
          depth_q <= REG_WDATA[CFG_DEPTH_LSB +: TYPE_W];
          ms_q    <= REG_WDATA[CFG_MS_LSB +: 3];
          wide_q  <= REG_WDATA[CFG_WIDE_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // issue sequencer; the kind checked is the one held before this go
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= rq_idle;
    end else if (CE) begin
      case (state_q)
        rq_idle:  state_q <= fire ? rq_issue : rq_idle;
        rq_issue: state_q <= LINK.req_ready ? rq_wait : rq_issue;
        rq_wait:  state_q <= LINK.resp_valid ? rq_idle : rq_wait;
        default:  state_q <= rq_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // results and sticky flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      done_q   <= 1'b0;
      refuse_q <= 1'b0;
      resp_q   <= resp_ok;
      rdata_q  <= RST_WORD;
    end else if (CE) begin
      if ((state_q == rq_wait) && LINK.resp_valid) begin
        done_q  <= 1'b1;
        resp_q  <= LINK.resp_status;
        rdata_q <= LINK.resp_data;
      end else if (w1c_done) begin
        done_q <= 1'b0;
      end
      if (go && (state_q == rq_idle) && bad) begin
        refuse_q <= 1'b1;
      end else if (w1c_refuse) begin
        refuse_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port, data in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      reg_rdata_q <= RST_WORD;
    end else if (CE) begin
      reg_rdata_q <= RST_WORD;
      if (REG_RD) begin
        case (REG_ADDR)
          OFS_DESC:   reg_rdata_q <= desc_q;
          OFS_ADDR:   reg_rdata_q <= addr_q;
          OFS_WDATA:  reg_rdata_q <= wdata_q;
          OFS_CTRL:   reg_rdata_q <= {29'h0, kind_q};
          OFS_CFG:    reg_rdata_q <= {23'h0, wide_q, 1'b0, ms_q, 1'b0, depth_q};
          OFS_STATUS: reg_rdata_q <= {26'h0, resp_q, 1'b0, refuse_q, done_q,
                                      state_q != rq_idle};
          OFS_RDATA:  reg_rdata_q <= rdata_q;
          default:    reg_rdata_q <= RST_WORD;
        endcase
      end
    end
  end

  assign REG_RDATA      = reg_rdata_q;
  assign LINK.req_valid = (state_q == rq_issue);
  assign LINK.req_kind  = msg_kind_t'(kind_q);
  assign LINK.req_desc  = desc_q;
  assign LINK.req_addr  = addr_q;
  assign LINK.req_wdata = wdata_q;

endmodule

// *** test/surface_state_decode_asserts.sv ***
// link checker between the requester end and the decoder end
`timescale 1ns/10ps
module surface_state_decode_asserts
  import surf_pkg::*;
(
  input wire logic                  SYS_CLK,
  input wire logic                  RESETN,
  input wire logic                  req_valid,
  input wire logic                  req_ready,
  input wire msg_kind_t             req_kind,
  input wire logic [DESC_W-1:0]     req_desc,
  input wire logic                  resp_valid,
  input wire resp_t                 resp_status,
  input wire logic [MSG_DATA_W-1:0] resp_data
);
  logic acc;
  logic nul;
  logic ok_ty;
  assign acc   = req_valid && req_ready;
  assign nul   = req_desc[31:29] == unbound_surface_type;
  assign ok_ty = !nul && req_desc[31:29] != reserved_surface_type && !req_desc[MBZ_BIT];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  AST_NULL_WR_DROP: assert property (acc && nul && req_kind inside {msg_write, msg_rt_write}
    |=> resp_valid && resp_status == resp_dropped) else $error("null write not dropped");
  AST_NULL_RD_ZERO: assert property (acc && nul && req_kind inside {msg_sample, msg_read}
    |=> resp_valid && resp_status == resp_zero && resp_data == '0) else $error("null read");
  AST_NULL_MEDIA_ERR: assert property (acc && nul && req_kind inside {msg_media_read,
    msg_media_write} |=> resp_valid && resp_status == resp_error) else $error("null media");
  AST_RSVD_TYPE_ERR: assert property (acc && req_desc[31:29] == reserved_surface_type
    |=> resp_valid && resp_status == resp_error) else $error("reserved type accepted");
  AST_VALIGN_RSVD: assert property (acc && ok_ty && req_kind inside {msg_sample, msg_rt_write}
    && req_desc[26:18] != 9'h1ff && req_desc[17] |=> resp_valid && resp_status == resp_error)
    else $error("reserved alignment accepted");
  AST_VALIGN_IGNORED: assert property (acc && ok_ty && req_kind == msg_write
    |=> resp_valid && resp_status == resp_ok) else $error("plain write not ok");
  AST_READ_LATENCY: assert property (acc && ok_ty && req_kind == msg_read
    |=> !resp_valid [*2] ##1 resp_valid && resp_status == resp_ok) else $error("read timing");
  AST_READY_BACK: assert property (resp_valid |-> !req_ready ##1 req_ready && !resp_valid)
    else $error("ready not back after answer");
  AST_REQ_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_desc)
    && $stable(req_kind)) else $error("request changed while waiting");
endmodule

// *** test/surface_state_decode_test.sv ***
// bench: requester and decoder joined over the message link
`timescale 1ns/10ps
module surface_state_decode_test;
  import surf_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] mem_rdata = 32'h0;
  logic [31:0] reg_rdata, mem_addr, mem_wdata, wr_data;
  logic        mem_rd, mem_wr;
  logic [8:0]  l_fm;
  logic [2:0]  l_ty;
  logic [1:0]  l_va, l_rs;
  logic        l_ar;
  int          fail_count = 0, cmp_count = 0, wr_cnt = 0, rd_cnt = 0;
  surf_msg_if link();
  always #2 sys_clk = ~sys_clk;
  surface_state_decode u_surface_state_decode (.SYS_CLK(sys_clk), .RESETN(resetn), .CE(ce),
    .LINK(link.device), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .LAST_TYPE(l_ty), .LAST_ARRAY(l_ar),
    .LAST_FORMAT(l_fm), .LAST_VALIGN(l_va), .LAST_RESP(l_rs));
  surface_requester u_surface_requester (.SYS_CLK(sys_clk), .RESETN(resetn), .CE(ce),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .LINK(link.requester));
  surface_state_decode_asserts u_surface_state_decode_asserts (.SYS_CLK(sys_clk),
    .RESETN(resetn), .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_kind(link.req_kind), .req_desc(link.req_desc), .resp_valid(link.resp_valid),
    .resp_status(link.resp_status), .resp_data(link.resp_data));
  // memory: answers a read one cycle later, counts writes
  always @(posedge sys_clk) begin
    mem_rdata <= mem_rd ? {mem_addr[15:0], 16'hbeef} : ~mem_rdata;
    if (mem_rd) rd_cnt <= rd_cnt + 1;
    if (mem_wr) begin
      wr_cnt  <= wr_cnt + 1;
      wr_data <= mem_wdata;
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  function automatic logic [31:0] mk(stype_t t, logic ar, fmt_t f, valign_t v);
    return {t, ar, 1'b0, f, v, 16'h0};
  endfunction
  task automatic run(logic [31:0] dsc, msg_kind_t k, logic rf, resp_t r, logic [31:0] a);
    logic [31:0] s;
    s = '0;
    wr(OFS_DESC, dsc);
    wr(OFS_ADDR, a);
    wr(OFS_WDATA, ~a);
    wr(OFS_CTRL, {29'h0, k});
    wr(OFS_CTRL, {23'h0, 1'b1, 5'h0, k});
    for (int i = 0; i < 20 && s[2:1] == 2'b00; i++) rd(OFS_STATUS, s);
    chk("answered", 32'h1, {31'h0, |s[2:1]});
    chk("refused", {31'h0, rf}, {31'h0, s[2]});
    if (!rf) chk("resp", {30'h0, r}, {30'h0, s[5:4]});
    wr(OFS_STATUS, 32'h6);
  endtask
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  // ----
  // tests
  // ----
  initial begin
    fmt_t lf[4] = '{packed_luma_chroma_plain, packed_luma_chroma_swap_a,
                    packed_luma_chroma_swap_b, packed_luma_chroma_swap_c};
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc("status", OFS_STATUS, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    wr(OFS_CFG, 32'h1);
    ce <= 1'b0;
    wr(OFS_DESC, 32'hffff_ffff);
    ce <= 1'b1;
    rdc("frozen desc", OFS_DESC, 32'h0);
    $display("test reset done");
    run(mk(two_dim_type, 0, 9'h0, 2'h2), msg_write, 0, resp_ok, 32'h100);
    chk("mem data", ~32'h100, wr_data);
    run(mk(unbound_surface_type, 0, 9'h0ab, 2'h3), msg_rt_write, 0, resp_dropped, 32'h4);
    chk("last", {15'h0, unbound_surface_type, 1'b0, 9'h0, vert_align_two_rows,
        resp_dropped}, {15'h0, l_ty, l_ar, l_fm, l_va, l_rs});
    run(mk(unbound_surface_type, 0, 9'h0, 2'h0), msg_rt_write, 0, resp_dropped, 32'h8);
    chk("writes", 32'd1, wr_cnt);
    for (int t = 0; t < 6; t++) begin
      run(mk(stype_t'(t), 0, 9'h0, 2'h0), msg_read, 0, resp_ok, t);
      rdc("rdata", OFS_RDATA, {t[15:0], 16'hbeef});
    end
    run(mk(cubemap_type, 1, 9'h0, 2'h0), msg_sample, 0, resp_ok, 32'h20);
    chk("last", {15'h0, cubemap_type, 1'b1, 9'h0, vert_align_two_rows,
        resp_ok}, {15'h0, l_ty, l_ar, l_fm, l_va, l_rs});
    run(mk(unbound_surface_type, 0, 9'h0, 2'h0), msg_sample, 0, resp_zero, 32'h24);
    rdc("rdata", OFS_RDATA, 32'h0);
    run(mk(unbound_surface_type, 0, 9'h0, 2'h0), msg_read, 0, resp_zero, 32'h28);
    chk("reads", 32'd7, rd_cnt);
    run(mk(unbound_surface_type, 0, 9'h0, 2'h0), msg_media_read, 0, resp_error, 0);
    run(mk(unbound_surface_type, 0, 9'h0, 2'h0), msg_media_write, 0, resp_error, 0);
    run(mk(reserved_surface_type, 0, 9'h0, 2'h0), msg_read, 0, resp_error, 0);
    run(mk(two_dim_type, 0, 9'h0, 2'h2), msg_sample, 0, resp_error, 0);
    run(mk(two_dim_type, 0, 9'h1ff, 2'h3), msg_sample, 0, resp_ok, 0);
    $display("test link done");
    run(mk(volume_type, 0, 9'h0, 2'h0), msg_rt_write, 1, resp_ok, 0);
    run(mk(volume_type, 1, 9'h0, 2'h0), msg_read, 1, resp_ok, 0);
    run(mk(two_dim_type, 0, 9'h0, 2'h0) | 32'h0800_0000, msg_read, 1, resp_ok, 0);
    foreach (lf[i]) run(mk(two_dim_type, 0, lf[i], 2'h1), msg_sample, 1, resp_ok, 0);
    wr(OFS_CFG, 32'h111);
    run(mk(two_dim_type, 0, 9'h0, 2'h0), msg_read, 1, resp_ok, 0);
    chk("writes", 32'd1, wr_cnt);
    $display("test checks done");
    end_sim();
  end
endmodule
